// ==== testbench/lbbc_tb_top.sv ====
/*
 * Self-checking bench for the backlight boost control block: register access,
 * enables, soft start, current slew and over-voltage hiccup.
 * Assumes the design's own assertions stand inside its files; shortened counts.
 */
`timescale 1ns/1ns
`default_nettype none
module lbbc_tb_top;
    import lbbc_pkg::*;
    localparam int STEP = 4;
    localparam int SS   = 8;

    logic       CLK = 1'b0;
    logic       RST = 1'b1;
    logic       GLOBAL_ENABLE = 1'b0;
    logic       OVERVOLTAGE_SENSE_INPUT = 1'b0;
    logic       REG_WR = 1'b0;
    logic       REG_RD = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    wire  [7:0] REG_RDATA;
    wire        CONVERTER_ON, SWITCHING_CLOCK_SELECT, SOFTSTART_ACTIVE, ERROR_AMP_RESET;
    wire        CURRENT_RANGE_SELECT, RAMP_BUSY;
    wire  [4:0] SINK1_CODE, SINK2_CODE;
    int         fails = 0;
    int         total_checks = 0;

    lbbc_top #(.STEP_CYCLES(STEP), .SOFTSTART_CYCLES(SS)) dut_u (
        .CLK(CLK), .RST(RST), .GLOBAL_ENABLE(GLOBAL_ENABLE),
        .OVERVOLTAGE_SENSE_INPUT(OVERVOLTAGE_SENSE_INPUT),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .CONVERTER_ON(CONVERTER_ON),
        .SWITCHING_CLOCK_SELECT(SWITCHING_CLOCK_SELECT), .SOFTSTART_ACTIVE(SOFTSTART_ACTIVE),
        .ERROR_AMP_RESET(ERROR_AMP_RESET), .CURRENT_RANGE_SELECT(CURRENT_RANGE_SELECT),
        .SINK1_CODE(SINK1_CODE), .SINK2_CODE(SINK2_CODE), .RAMP_BUSY(RAMP_BUSY)
    );

    always #25 CLK = ~CLK;

    // =========================================================================
    // Shared tasks
    // =========================================================================
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge CLK);
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(negedge CLK);
        REG_RD = 1'b0;
        check(REG_RDATA, exp);
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = CONVERTER_ON;
            1: pick = SOFTSTART_ACTIVE;
            default: pick = RAMP_BUSY;
        endcase
    endfunction

    // Bounded wait on one status output
    task automatic wait_sig(input int sel, input logic val);
        int n;
        n = 0;
        while (pick(sel) !== val && n < 200) begin
            @(negedge CLK);
            n++;
        end
        if (n == 200) begin
            fails++;
            $display("BAD %0t: wait on status %0d timed out", $time, sel);
            complete_run();
        end
    endtask

    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        int         last;
        int         cyc;
        int         nchg;
        logic [4:0] prev;
        repeat (4) @(negedge CLK);
        RST = 1'b0;
        rd_chk(LBBC_CURRENT_OFFSET, 8'h40);
        rd_chk(LBBC_CONTROL_OFFSET, 8'h02);
        check(SWITCHING_CLOCK_SELECT, 8'h01);
        check(CURRENT_RANGE_SELECT, 8'h01);
        check(SINK1_CODE, 8'h00);
        check(CONVERTER_ON, 8'h00);
        check(ERROR_AMP_RESET, 8'h01);
        rd_chk(8'h55, 8'h00);
        wr(LBBC_CONTROL_OFFSET, 8'hff);
        rd_chk(LBBC_CONTROL_OFFSET, 8'hcf);
        check(SWITCHING_CLOCK_SELECT, 8'h01);
        wr(LBBC_CONTROL_OFFSET, 8'h00);
        repeat (2) @(negedge CLK);
        check(SWITCHING_CLOCK_SELECT, 8'h00);
        // Global enable alone must leave the converter off
        GLOBAL_ENABLE = 1'b1;
        repeat (10) @(negedge CLK);
        check(CONVERTER_ON, 8'h00);
        // Enable together with range and code in one byte
        wr(LBBC_CURRENT_OFFSET, 8'h85);
        wait_sig(0, 1'b1);
        check(SOFTSTART_ACTIVE, 8'h01);
        check(SINK1_CODE, 8'h05);
        check(CURRENT_RANGE_SELECT, 8'h00);
        wait_sig(1, 1'b0);
        check(CONVERTER_ON, 8'h01);
        check(ERROR_AMP_RESET, 8'h00);
        // Ramp upward while running; a write during the ramp loses its code
        wr(LBBC_CURRENT_OFFSET, 8'h88);
        wait_sig(2, 1'b1);
        wr(LBBC_CURRENT_OFFSET, 8'h9f);
        prev = SINK1_CODE;
        last = 0;
        nchg = 0;
        cyc = 0;
        while ((RAMP_BUSY !== 1'b0 || SINK1_CODE !== 5'h08) && cyc < 200) begin
            @(negedge CLK);
            cyc++;
            if (SINK1_CODE !== prev) begin
                check(SINK1_CODE, prev + 5'h01);
                check(SINK2_CODE, SINK1_CODE);
                if (nchg > 0)
                    check(cyc - last, STEP);
                nchg++;
                last = cyc;
                prev = SINK1_CODE;
            end
        end
        check(SINK1_CODE, 8'h08);
        check(nchg > 1, 8'h01);
        rd_chk(LBBC_CURRENT_OFFSET, 8'h88);
        // Over-voltage keeps restarting soft start while it persists
        OVERVOLTAGE_SENSE_INPUT = 1'b1;
        wait_sig(1, 1'b1);
        check(ERROR_AMP_RESET, 8'h01);
        repeat (3 * SS) @(negedge CLK);
        check(SOFTSTART_ACTIVE, 8'h01);
        OVERVOLTAGE_SENSE_INPUT = 1'b0;
        wait_sig(1, 1'b0);
        check(ERROR_AMP_RESET, 8'h00);
        // Local enable off, then global enable off; contents kept
        wr(LBBC_CURRENT_OFFSET, 8'h08);
        wait_sig(0, 1'b0);
        wr(LBBC_CURRENT_OFFSET, 8'h88);
        wait_sig(0, 1'b1);
        GLOBAL_ENABLE = 1'b0;
        wait_sig(0, 1'b0);
        rd_chk(LBBC_CURRENT_OFFSET, 8'h88);
        // Reset during soft start reloads defaults
        GLOBAL_ENABLE = 1'b1;
        wait_sig(0, 1'b1);
        RST = 1'b1;
        repeat (2) @(negedge CLK);
        RST = 1'b0;
        check(CONVERTER_ON, 8'h00);
        rd_chk(LBBC_CURRENT_OFFSET, 8'h40);
        rd_chk(LBBC_CONTROL_OFFSET, 8'h02);
        complete_run();
    end
endmodule
`default_nettype wire

// ==== verilog/lbbc_pkg.sv ====
/*
 * Shared constants and types for the backlight boost control block.
 * Assumes a 20 MHz converter-side control clock and byte-wide registers.
 */
package lbbc_pkg;

    // =========================================================================
    // Register offsets and field positions
    // =========================================================================
    localparam logic [7:0] LBBC_CURRENT_OFFSET   = 8'h86;
    localparam logic [7:0] LBBC_CONTROL_OFFSET   = 8'h87;
    localparam int         LBBC_ENABLE_BIT       = 7;
    localparam int         LBBC_RANGE_BIT        = 6;
    localparam int         LBBC_CLKSEL_BIT       = 1;
    localparam int         LBBC_CODE_W           = 5;

    // =========================================================================
    // Reset values and write masks
    // =========================================================================
    localparam logic [7:0] LBBC_CURRENT_RESET    = 8'h40;
    localparam logic [7:0] LBBC_CONTROL_RESET    = 8'h02;
    localparam logic [7:0] LBBC_CURRENT_WMASK    = 8'hff;
    localparam logic [7:0] LBBC_CONTROL_WMASK    = 8'hcf;

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int         LBBC_CLK_HZ           = 20_000_000;
    localparam int         LBBC_STEP_US          = 32;
    localparam int         LBBC_STEP_CYCLES      = LBBC_STEP_US * (LBBC_CLK_HZ / 1_000_000);
    localparam int         LBBC_SOFTSTART_CYCLES = 2 * LBBC_STEP_CYCLES;
    localparam logic [4:0] LBBC_CODE_ZERO        = 5'h00;

    // =========================================================================
    // Types
    // =========================================================================
    typedef enum logic [1:0] {
        LBBC_OFF,
        LBBC_SOFTSTART,
        LBBC_RUN
    } lbbc_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lbbc_reg_req_t;

endpackage

// ==== verilog/lbbc_ramp.sv ====
/*
 * Slew ramp for the sink-current code: one step per step period toward target.
 * Assumes load is pulsed only when a new target is accepted.
 */
`timescale 1ns/1ns
`default_nettype none
module lbbc_ramp
    import lbbc_pkg::*;
#(
    parameter int CODE_W      = LBBC_CODE_W,
    parameter int STEP_CYCLES = LBBC_STEP_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              hold,
    input  wire logic              load,
    input  wire logic [CODE_W-1:0] target,
    output logic [CODE_W-1:0]      code,
    output logic                   busy
);
    localparam int CNT_W = $clog2(STEP_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    logic [CODE_W-1:0] code_reg;
    logic [CODE_W-1:0] target_reg;
    logic [CNT_W-1:0]  cnt_reg;
    wire               step_due = (cnt_reg == CNT_LAST);
    wire               moving   = (code_reg != target_reg);
    wire [CODE_W-1:0]  code_next = (target_reg > code_reg) ? code_reg + CODE_W'(1)
                                                           : code_reg - CODE_W'(1);

    always_ff @(posedge clk) begin
        if (rst) begin
            code_reg   <= '0;
            target_reg <= '0;
            cnt_reg    <= '0;
        end else if (hold) begin
            code_reg   <= target;
            target_reg <= target;
            cnt_reg    <= '0;
        end else begin
            if (load) begin
                target_reg <= target;
            end
            if (!moving || step_due) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + CNT_ONE;
            end
            if (moving && step_due) begin
                code_reg <= code_next;
            end
        end
    end

    assign code = code_reg;
    assign busy = moving;
endmodule
`default_nettype wire

// ==== verilog/lbbc_top.sv ====
/*
 * Backlight boost converter digital control: registers, enables, soft start,
 * current slew and over-voltage hiccup. Assumes a byte register port from the
 * embedded controller and an already-compared over-voltage input from a pin.
 */
`timescale 1ns/1ns
`default_nettype none
module lbbc_top
    import lbbc_pkg::*;
#(
    parameter int STEP_CYCLES      = LBBC_STEP_CYCLES,
    parameter int SOFTSTART_CYCLES = LBBC_SOFTSTART_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       GLOBAL_ENABLE,
    input  wire logic       OVERVOLTAGE_SENSE_INPUT,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic [7:0]      REG_RDATA,
    output logic            CONVERTER_ON,
    output logic            SWITCHING_CLOCK_SELECT,
    output logic            SOFTSTART_ACTIVE,
    output logic            ERROR_AMP_RESET,
    output logic            CURRENT_RANGE_SELECT,
    output logic [4:0]      SINK1_CODE,
    output logic [4:0]      SINK2_CODE,
    output logic            RAMP_BUSY
);
    // =========================================================================
    // Input synchronisers
    // =========================================================================
    logic gen_meta_reg, gen_reg, ov_meta_reg, ov_reg;
    always_ff @(posedge CLK) begin
        gen_meta_reg <= GLOBAL_ENABLE;
        gen_reg      <= gen_meta_reg;
        ov_meta_reg  <= OVERVOLTAGE_SENSE_INPUT;
        ov_reg       <= ov_meta_reg;
    end

    // =========================================================================
    // Registers
    // =========================================================================
    lbbc_reg_req_t req;
    assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

    logic [7:0] current_reg;
    logic [7:0] control_reg;
    logic       ramp_busy;
    logic [4:0] ramp_code;
    lbbc_state_t state_reg;
    lbbc_state_t state_next;

    wire wr_current = req.wr && (req.addr == LBBC_CURRENT_OFFSET);
    wire wr_control = req.wr && (req.addr == LBBC_CONTROL_OFFSET);
    // Code field change is refused mid-ramp; enable, range still take effect
    wire        code_locked  = ramp_busy && (state_reg == LBBC_RUN);
    wire [4:0]  code_kept    = current_reg[LBBC_CODE_W-1:0];
    wire [4:0]  code_written = code_locked ? code_kept : req.wdata[LBBC_CODE_W-1:0];
    wire [7:0]  current_next = {req.wdata[7:LBBC_CODE_W], code_written};
    wire        code_change  = wr_current && !code_locked && (code_written != code_kept);
    // Ramp follows the stored code, or the code being written in this cycle
    wire [4:0]  ramp_target  = wr_current ? code_written : code_kept;

    always_ff @(posedge CLK) begin
        if (RST) begin
            current_reg <= LBBC_CURRENT_RESET;
            control_reg <= LBBC_CONTROL_RESET;
        end else begin
            if (wr_current) begin
                current_reg <= current_next & LBBC_CURRENT_WMASK;
            end
            if (wr_control) begin
                control_reg <= req.wdata & LBBC_CONTROL_WMASK;
            end
        end
    end

    wire local_enable = current_reg[LBBC_ENABLE_BIT];
    wire run_allowed  = gen_reg && local_enable;

    // =========================================================================
    // Enable, soft start and over-voltage hiccup
    // =========================================================================
    localparam int SS_W = $clog2(SOFTSTART_CYCLES + 1);
    localparam logic [SS_W-1:0] SS_LAST = SS_W'(SOFTSTART_CYCLES - 1);
    localparam logic [SS_W-1:0] SS_ONE  = SS_W'(1);

    logic [SS_W-1:0] ss_cnt_reg;
    wire             ss_done = (ss_cnt_reg == SS_LAST);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LBBC_OFF: begin
                if (run_allowed) state_next = LBBC_SOFTSTART;
            end
            LBBC_SOFTSTART: begin
                if (!run_allowed) state_next = LBBC_OFF;
                else if (ss_done && !ov_reg) state_next = LBBC_RUN;
            end
            LBBC_RUN: begin
                if (!run_allowed) state_next = LBBC_OFF;
                else if (ov_reg) state_next = LBBC_SOFTSTART;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg   <= LBBC_OFF;
            ss_cnt_reg  <= '0;
        end else begin
            state_reg   <= state_next;
            if (state_next != LBBC_SOFTSTART || state_reg != LBBC_SOFTSTART || ov_reg) begin
                ss_cnt_reg <= '0;
            end else if (!ss_done) begin
                ss_cnt_reg <= ss_cnt_reg + SS_ONE;
            end
        end
    end

    // =========================================================================
    // Current slew
    // =========================================================================
    lbbc_ramp #(
        .CODE_W      (LBBC_CODE_W),
        .STEP_CYCLES (STEP_CYCLES)
    ) u_ramp (
        .clk    (CLK),
        .rst    (RST),
        .hold   (state_reg != LBBC_RUN),
        .load   (code_change),
        .target (ramp_target),
        .code   (ramp_code),
        .busy   (ramp_busy)
    );

    // =========================================================================
    // Output flops
    // =========================================================================
    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA              <= 8'h00;
            CONVERTER_ON           <= 1'b0;
            SWITCHING_CLOCK_SELECT <= LBBC_CONTROL_RESET[LBBC_CLKSEL_BIT];
            SOFTSTART_ACTIVE       <= 1'b0;
            ERROR_AMP_RESET        <= 1'b1;
            CURRENT_RANGE_SELECT   <= LBBC_CURRENT_RESET[LBBC_RANGE_BIT];
            SINK1_CODE             <= LBBC_CODE_ZERO;
            SINK2_CODE             <= LBBC_CODE_ZERO;
            RAMP_BUSY              <= 1'b0;
        end else begin
            REG_RDATA              <= !req.rd ? 8'h00 :
                                      (req.addr == LBBC_CURRENT_OFFSET) ? current_reg :
                                      (req.addr == LBBC_CONTROL_OFFSET) ? control_reg : 8'h00;
            CONVERTER_ON           <= (state_next != LBBC_OFF);
            SWITCHING_CLOCK_SELECT <= control_reg[LBBC_CLKSEL_BIT];
            SOFTSTART_ACTIVE       <= (state_next == LBBC_SOFTSTART);
            ERROR_AMP_RESET        <= (state_next == LBBC_OFF) || ov_reg;
            CURRENT_RANGE_SELECT   <= current_reg[LBBC_RANGE_BIT];
            SINK1_CODE             <= ramp_code;
            SINK2_CODE             <= ramp_code;
            RAMP_BUSY              <= ramp_busy && (state_reg == LBBC_RUN);
        end
    end

    // =========================================================================
    // Assertions
    // =========================================================================
    property p_clk_sel;
        @(posedge CLK) disable iff (RST) 1'b1 |=> SWITCHING_CLOCK_SELECT == $past(control_reg[LBBC_CLKSEL_BIT]);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select mismatch");

    property p_off_without_enable;
        @(posedge CLK) disable iff (RST) !run_allowed |=> !CONVERTER_ON;
    endproperty
    a_off_without_enable: assert property (p_off_without_enable) else $error("converter on, enable low");

    property p_reset_defaults;
        @(posedge CLK) RST |=> current_reg == LBBC_CURRENT_RESET && control_reg == LBBC_CONTROL_RESET && !CONVERTER_ON;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not loaded");

    property p_global_alone;
        @(posedge CLK) disable iff (RST) (gen_reg && !local_enable) |=> !CONVERTER_ON;
    endproperty
    a_global_alone: assert property (p_global_alone) else $error("started on global enable alone");

    sequence s_enable_rise;
        $rose(run_allowed) && state_reg == LBBC_OFF;
    endsequence
    property p_softstart;
        @(posedge CLK) disable iff (RST) s_enable_rise |=> state_reg == LBBC_SOFTSTART ##0 SOFTSTART_ACTIVE;
    endproperty
    a_softstart: assert property (p_softstart) else $error("soft start not entered");

    property p_write_running;
        @(posedge CLK) disable iff (RST) (wr_current && !code_locked) |=> current_reg == $past(req.wdata);
    endproperty
    a_write_running: assert property (p_write_running) else $error("current write lost");

    property p_step_size;
        @(posedge CLK) disable iff (RST)
            (state_reg == LBBC_RUN && $past(state_reg) == LBBC_RUN && ramp_code != $past(ramp_code))
            |-> (ramp_code - $past(ramp_code) == 5'h01) || ($past(ramp_code) - ramp_code == 5'h01);
    endproperty
    a_step_size: assert property (p_step_size) else $error("ramp jumped more than one step");

    property p_locked;
        @(posedge CLK) disable iff (RST) (wr_current && code_locked) |=> current_reg[4:0] == $past(current_reg[4:0]);
    endproperty
    a_locked: assert property (p_locked) else $error("code changed during ramp");

    property p_hiccup;
        @(posedge CLK) disable iff (RST)
            (ov_reg && state_reg == LBBC_RUN && run_allowed) |=> state_reg == LBBC_SOFTSTART;
    endproperty
    a_hiccup: assert property (p_hiccup) else $error("no hiccup on over-voltage");

    property p_sinks_equal;
        @(posedge CLK) disable iff (RST)
            SINK1_CODE == SINK2_CODE && CURRENT_RANGE_SELECT == $past(current_reg[LBBC_RANGE_BIT]);
    endproperty
    a_sinks_equal: assert property (p_sinks_equal) else $error("sinks differ");
endmodule
`default_nettype wire
